// ==== sgc_switch_ctrl.v ====
// identity and global control register bank with aging control
`timescale 1ns/10ps
`include "sgc_defs.vh"
module sgc_switch_ctrl #(
	parameter [7:0] FAMILY_CODE = 8'h5a,   // arbitrary value
	parameter [3:0] CHIP_CODE = 4'h9,      // arbitrary value
	parameter [2:0] REV_CODE = 3'h2,       // arbitrary value
	parameter NUM_PORTS = 2,
	parameter [39:0] FAST_AGE_CYCLES = `SGC_FAST_AGE_CYC,
	parameter [39:0] NORM_AGE_CYCLES = `SGC_NORM_AGE_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// axi4-lite write address
	input wire [`SGC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`SGC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// switch engine frame screening
	input wire frm_valid,
	input wire [15:0] frm_len,
	input wire [15:0] frm_len_type,
	input wire frm_bad,
	input wire frm_is_pause,
	input wire sniffer_mode,
	input wire ingress_over,
	input wire [NUM_PORTS-1:0] port_link,
	// switch engine control levels
	output reg switch_enable,
	output reg frm_accept,
	output reg frm_drop,
	output reg tx_pause_en,
	output reg rx_pause_en,
	output reg ingress_send_pause,
	output reg aggressive_backoff,
	output reg ctl2_len_bits_masked,
	output reg age_tick,
	output reg age_flush_all
);
	// ******************************************
	// registers
	// ******************************************
	reg start_reg;
	reg [15:0] gctl_reg;
	reg [NUM_PORTS-1:0] link_s1_reg;
	reg [NUM_PORTS-1:0] link_s2_reg;
	reg [NUM_PORTS-1:0] link_d_reg;
	reg link_fast_reg;
	reg [`SGC_ADDR_W-1:0] aw_reg;
	reg aw_have_reg;
	reg [31:0] w_reg;
	reg [3:0] ws_reg;
	reg w_have_reg;
	wire [15:0] ident_word;
	wire link_lost;
	wire timer_tick;
	wire use_fast;
	wire [39:0] period;

	function [31:0] rd_mux;
		input [`SGC_ADDR_W-1:0] a;
		input [15:0] id;
		input [15:0] g;
		begin
			case (a)
				`SGC_BYTE_IDENT: rd_mux = {16'h0000, id};
				`SGC_BYTE_GCTL1: rd_mux = {16'h0000, g};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	endfunction

	function hit;
		input [`SGC_ADDR_W-1:0] a;
		begin
			hit = (a == `SGC_BYTE_IDENT) || (a == `SGC_BYTE_GCTL1);
		end
	endfunction

	// read-only codes with live start bit
	assign ident_word = {FAMILY_CODE, CHIP_CODE, REV_CODE, start_reg};

	// ******************************************
	// control word decode
	// ******************************************
	wire pass_all_on;
	wire long_ok;
	wire len_field_bad;
	wire ingress_drop;
	wire pause_filtered;
	wire link_age_on;
	wire wr_commit;
	wire wr_ident;
	wire wr_gctl;

	// debug pass-through counts only while a sniffer port is set up
	assign pass_all_on = gctl_reg[`SGC_B_PASS_ALL] && sniffer_mode;
	// both enables must allow long frames: either one at zero discards over 2000
	assign long_ok = gctl_reg[`SGC_B_RX2000] && gctl_reg[`SGC_B_RX2K];
	// type values from 1500 up are ethertypes and never checked
	assign len_field_bad = gctl_reg[`SGC_B_LEN_CHK] && (frm_len_type < `SGC_LEN_1500)
		&& (frm_len_type != frm_len);
	assign ingress_drop = ingress_over && !gctl_reg[`SGC_B_ING_FC];
	assign pause_filtered = frm_is_pause && !gctl_reg[`SGC_B_PASS_FC];
	assign link_age_on = gctl_reg[`SGC_B_LINK_AGE];
	// a write lands once address and data are both held and no answer is pending
	assign wr_commit = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_ident = wr_commit && (aw_reg == `SGC_BYTE_IDENT);
	assign wr_gctl = wr_commit && (aw_reg == `SGC_BYTE_GCTL1);

	// ******************************************
	// axi4-lite write path
	// ******************************************
	// address and data latch independently, either may come first
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_reg <= {`SGC_ADDR_W{1'b0}};
			w_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SGC_AXI_OKAY;
			start_reg <= `SGC_START_RST;
			gctl_reg <= `SGC_GCTL1_RST;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && !aw_have_reg && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				aw_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
			end
			if (s_axi_wvalid && !w_have_reg && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
				w_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
			end
			if (wr_commit) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= hit(aw_reg) ? `SGC_AXI_OKAY : `SGC_AXI_SLVERR;
				if (wr_ident && ws_reg[0]) begin
					start_reg <= w_reg[`SGC_START_BIT];
				end
				// reserved fields are plain storage, so a read-merge-write keeps them
				if (wr_gctl) begin
					if (ws_reg[0]) begin
						gctl_reg[7:0] <= w_reg[7:0];
					end
					if (ws_reg[1]) begin
						gctl_reg[15:8] <= w_reg[15:8];
					end
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ******************************************
	// axi4-lite read path
	// ******************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SGC_AXI_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux(s_axi_araddr, ident_word, gctl_reg);
				s_axi_rresp <= hit(s_axi_araddr) ? `SGC_AXI_OKAY : `SGC_AXI_SLVERR;
			end
		end
	end

	// ******************************************
	// frame screening and engine levels
	// ******************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			frm_accept <= 1'b0;
			frm_drop <= 1'b0;
			switch_enable <= 1'b0;
			tx_pause_en <= 1'b0;
			rx_pause_en <= 1'b0;
			ingress_send_pause <= 1'b0;
			aggressive_backoff <= 1'b0;
			ctl2_len_bits_masked <= 1'b0;
		end else begin
			switch_enable <= start_reg;
			tx_pause_en <= gctl_reg[`SGC_B_TX_FC];
			rx_pause_en <= gctl_reg[`SGC_B_RX_FC];
			aggressive_backoff <= gctl_reg[`SGC_B_AGGR_BO];
			ctl2_len_bits_masked <= gctl_reg[`SGC_B_RX2K];
			ingress_send_pause <= ingress_over && gctl_reg[`SGC_B_ING_FC];
			frm_accept <= 1'b0;
			frm_drop <= 1'b0;
			if (frm_valid) begin
				if (!start_reg) begin
					frm_drop <= 1'b1;
				end else if (pass_all_on) begin
					frm_accept <= 1'b1;
				end else if (frm_bad) begin
					frm_drop <= 1'b1;
				end else if (ingress_drop) begin
					frm_drop <= 1'b1;
				end else if (frm_len > `SGC_LEN_2000 && !long_ok) begin
					frm_drop <= 1'b1;
				end else if (len_field_bad) begin
					frm_drop <= 1'b1;
				end else if (pause_filtered) begin
					// pause frames are filtered unless forwarding is asked for
					frm_drop <= 1'b1;
				end else begin
					frm_accept <= 1'b1;
				end
			end
		end
	end

	// ******************************************
	// aging control
	// ******************************************
	// link pins are asynchronous to ref_clk
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			link_s1_reg <= {NUM_PORTS{1'b0}};
			link_s2_reg <= {NUM_PORTS{1'b0}};
			link_d_reg <= {NUM_PORTS{1'b0}};
		end else begin
			link_s1_reg <= port_link;
			link_s2_reg <= link_s1_reg;
			link_d_reg <= link_s2_reg;
		end
	end
	assign link_lost = |(link_d_reg & ~link_s2_reg);

	// one fast cycle after a link loss, then back to normal
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			link_fast_reg <= 1'b0;
		end else if (link_lost && link_age_on) begin
			link_fast_reg <= 1'b1;
		end else if (timer_tick) begin
			link_fast_reg <= 1'b0;
		end
	end

	// normal period leaves out the extra 75 s spread
	assign use_fast = gctl_reg[`SGC_B_FAST_AGE] || link_fast_reg;
	assign period = use_fast ? FAST_AGE_CYCLES : NORM_AGE_CYCLES;

	sgc_age_timer #(
		.CNT_W(40)
	) u_age_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(gctl_reg[`SGC_B_AGE_EN]),
		.restart(link_lost && link_age_on),
		.period(period),
		.tick(timer_tick)
	);

	// ******************************************
	// aging outputs
	// ******************************************
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			age_tick <= 1'b0;
			age_flush_all <= 1'b0;
		end else begin
			age_tick <= timer_tick;
			age_flush_all <= link_lost;
		end
	end
endmodule // sgc_switch_ctrl

// ==== sgc_defs.vh ====
// constants for the switch identity and global control register bank
`ifndef SGC_DEFS_VH
`define SGC_DEFS_VH
// ******************************************
// register map
// ******************************************
`define SGC_ADDR_W 12
`define SGC_OFS_IDENT 12'h000
`define SGC_OFS_GCTL1 12'h002
`define SGC_BYTE_IDENT 12'h000
`define SGC_BYTE_GCTL1 12'h008
// ******************************************
// identity fields
// ******************************************
`define SGC_FAMILY_LSB 8
`define SGC_CHIP_LSB 4
`define SGC_REV_LSB 1
`define SGC_START_BIT 0
`define SGC_START_RST 1'b1
// ******************************************
// control word fields
// ******************************************
`define SGC_B_PASS_ALL 15
`define SGC_B_RX2000 14
`define SGC_B_TX_FC 13
`define SGC_B_RX_FC 12
`define SGC_B_LEN_CHK 11
`define SGC_B_AGE_EN 10
`define SGC_B_FAST_AGE 9
`define SGC_B_AGGR_BO 8
`define SGC_B_ING_FC 5
`define SGC_B_RX2K 4
`define SGC_B_PASS_FC 3
`define SGC_B_LINK_AGE 0
`define SGC_GCTL1_RST 16'h3450
`define SGC_LEN_2000 16'h07d0
`define SGC_LEN_1500 16'h05dc
// ******************************************
// timing
// ******************************************
`define SGC_CLK_MHZ 200
`define SGC_FAST_AGE_US 800
// 800 us at 200 MHz, sized to the 40-bit period
`define SGC_FAST_AGE_CYC 40'd160000
`define SGC_NORM_AGE_S 300
// 300 s at 200 MHz
`define SGC_NORM_AGE_CYC 40'hdf8475800
`define SGC_NORM_AGE_JIT_S 75
`define SGC_AXI_OKAY 2'b00
`define SGC_AXI_SLVERR 2'b10
`endif

// ==== sgc_age_timer.v ====
// aging period timer: emits one age tick per elapsed period
`timescale 1ns/10ps
`include "sgc_defs.vh"
module sgc_age_timer #(
	parameter CNT_W = 40
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// control
	input wire run,
	input wire restart,
	input wire [CNT_W-1:0] period,
	// tick out
	output reg tick
);
	reg [CNT_W-1:0] cnt_reg;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_reg <= {CNT_W{1'b0}};
			tick <= 1'b0;
		end else if (restart || !run) begin
			cnt_reg <= {CNT_W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_reg >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
			cnt_reg <= {CNT_W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end
endmodule // sgc_age_timer

// ==== sgc_switch_ctrl_props.sv ====
// assertion checker for the switch control register bank
`timescale 1ns/10ps
// ****
// checker
// ****
module sgc_chk (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// bus answers
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// frame screen
	input wire frm_valid,
	input wire frm_bad,
	input wire sniffer_mode,
	input wire ingress_over,
	input wire [1:0] port_link,
	input wire frm_accept,
	input wire frm_drop,
	input wire ingress_send_pause,
	input wire age_flush_all
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response withdrawn early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data withdrawn early");
	property p_rans;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read not answered next cycle");
	property p_rup;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_rup: assert property (p_rup) else $error("upper read lanes not zero");
	property p_one;
		frm_valid |=> frm_accept != frm_drop;
	endproperty
	a_one: assert property (p_one) else $error("frame not judged exactly once");
	property p_idle;
		!frm_valid |=> !frm_accept && !frm_drop;
	endproperty
	a_idle: assert property (p_idle) else $error("verdict without a frame");
	property p_bad;
		frm_valid && frm_bad && !sniffer_mode |=> frm_drop;
	endproperty
	a_bad: assert property (p_bad) else $error("bad frame passed outside sniffing");
	property p_ing;
		ingress_send_pause |-> $past(ingress_over);
	endproperty
	a_ing: assert property (p_ing) else $error("pause request without overrun");
	property p_flush;
		|($past(port_link) & ~port_link) |-> ##[1:6] age_flush_all;
	endproperty
	a_flush: assert property (p_flush) else $error("link loss did not flush table");
endmodule // sgc_chk

bind sgc_switch_ctrl sgc_chk u_chk (.ref_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frm_valid, .frm_bad,
	.sniffer_mode, .ingress_over, .port_link, .frm_accept, .frm_drop, .ingress_send_pause, .age_flush_all);

// ==== tb.sv ====
// self-checking bench for the switch control register bank
`timescale 1ns/10ps
`include "sgc_defs.vh"
module tb;
	// ****
	// signals
	// ****
	localparam [11:0] a_id = `SGC_BYTE_IDENT;
	localparam [11:0] a_gc = `SGC_BYTE_GCTL1;
	localparam [1:0] ok = `SGC_AXI_OKAY;
	localparam [1:0] se = `SGC_AXI_SLVERR;
	logic ref_clk = 1'b0, rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, frm_valid = 1'b0, frm_bad = 1'b0, frm_is_pause = 1'b0;
	logic sniffer_mode = 1'b0, ingress_over = 1'b0;
	logic [15:0] frm_len = 16'h0, frm_len_type = 16'h0, rv;
	logic [1:0] port_link = 2'h3;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire switch_enable, frm_accept, frm_drop, tx_pause_en, rx_pause_en, ingress_send_pause;
	wire aggressive_backoff, ctl2_len_bits_masked, age_tick, age_flush_all;
	int mismatches = 0, check_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	// short aging periods keep the run brief
	sgc_switch_ctrl #(.FAST_AGE_CYCLES(40'd20), .NORM_AGE_CYCLES(40'd100)) dut (.*);
	// ****
	// shared tasks
	// ****
	task automatic chk(input string n, input [31:0] e, input [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task automatic wr(input [11:0] a, input [15:0] d, input [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
		@(posedge ref_clk);
	endtask
	task automatic rd(input [11:0] a, input [15:0] e, input [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata[15:0];
		chk("rdata", {16'h0, e}, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		@(posedge ref_clk);
	endtask
	task automatic flushes(input int cyc, input int e);
		int c = 0;
		repeat (cyc) begin
			@(posedge ref_clk);
			if (age_flush_all === 1'b1) c++;
		end
		chk("flush count", e, c);
	endtask
	task automatic fr(input [15:0] l, input [15:0] lt, input b, input p, input ea);
		frm_len <= l;
		frm_len_type <= lt;
		frm_bad <= b;
		frm_is_pause <= p;
		frm_valid <= 1'b1;
		@(posedge ref_clk);
		frm_valid <= 1'b0;
		@(posedge ref_clk);
		chk("verdict", {ea, !ea}, {frm_accept, frm_drop});
	endtask
	// order: enable, tx pause, rx pause, back-off, length mask
	task automatic lv(input [4:0] e);
		repeat (3) @(posedge ref_clk);
		chk("levels", e, {switch_enable, tx_pause_en, rx_pause_en, aggressive_backoff, ctl2_len_bits_masked});
	endtask
	task automatic ticks(input int cyc, input int lo, input int hi);
		int c = 0;
		repeat (cyc) begin
			@(posedge ref_clk);
			if (age_tick === 1'b1) c++;
		end
		chk("tick count in range", 1, c >= lo && c <= hi);
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		rd(a_id, 16'h5a95, ok);
		rd(a_gc, 16'h3450, ok);
		lv(5'h1d);
	endtask
	task t_start;
		wr(a_id, 16'h0000, ok);
		rd(a_id, 16'h5a94, ok);
		lv(5'h0d);
		fr(16'd64, 16'd64, 1'b0, 1'b0, 1'b0);
		wr(a_id, 16'h0001, ok);
		fr(16'd64, 16'd64, 1'b0, 1'b0, 1'b1);
		wr(12'h00c, 16'hffff, se);
		rd(12'h00c, 16'h0000, se);
	endtask
	task t_ctrl;
		rd(a_gc, 16'h3450, ok);
		wr(a_gc, (rv & 16'h00c6) | 16'h0120, ok);
		rd(a_gc, 16'h0160, ok);
		lv(5'h12);
		ingress_over <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("ingress pause", 1, ingress_send_pause);
		fr(16'd100, 16'd100, 1'b0, 1'b0, 1'b1);
		ingress_over <= 1'b0;
		fr(16'd2000, 16'd2000, 1'b0, 1'b0, 1'b1);
		fr(16'd2001, 16'd2001, 1'b0, 1'b0, 1'b0);
		fr(16'd64, 16'd64, 1'b0, 1'b1, 1'b0);
		fr(16'd64, 16'd64, 1'b1, 1'b0, 1'b0);
		wr(a_gc, 16'h8968, ok);
		sniffer_mode <= 1'b1;
		fr(16'd64, 16'd64, 1'b1, 1'b0, 1'b1);
		sniffer_mode <= 1'b0;
		fr(16'd120, 16'd100, 1'b0, 1'b0, 1'b0);
		fr(16'd100, 16'd100, 1'b0, 1'b0, 1'b1);
		fr(16'd64, 16'd64, 1'b0, 1'b1, 1'b1);
		wr(a_gc, 16'hc978, ok);
		fr(16'd2001, 16'd2001, 1'b0, 1'b0, 1'b1);
		wr(a_gc, 16'h4440, ok);
		fr(16'd2001, 16'd2001, 1'b0, 1'b0, 1'b0);
		ingress_over <= 1'b1;
		fr(16'd64, 16'd64, 1'b0, 1'b0, 1'b0);
		ingress_over <= 1'b0;
	endtask
	// answers must stand while the master is not yet ready
	task t_hold;
		s_axi_awaddr <= a_gc;
		s_axi_wdata <= 32'h0000_0440;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		repeat (2) @(posedge ref_clk);
		s_axi_bready <= 1'b1;
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
		chk("held bvalid", 1, s_axi_bvalid);
		chk("held bresp", ok, s_axi_bresp);
		s_axi_araddr <= a_gc;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		repeat (2) @(posedge ref_clk);
		s_axi_rready <= 1'b1;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
		chk("held rvalid", 1, s_axi_rvalid);
		chk("held rdata", 32'h0000_0440, s_axi_rdata);
		@(posedge ref_clk);
	endtask
	task t_age;
		wr(a_gc, 16'h0440, ok);
		ticks(300, 2, 4);
		wr(a_gc, 16'h0640, ok);
		ticks(200, 8, 11);
		wr(a_gc, 16'h0040, ok);
		ticks(300, 0, 0);
		wr(a_gc, 16'h0441, ok);
		port_link <= 2'b01;
		flushes(8, 1);
		ticks(22, 1, 2);
		ticks(60, 0, 0);
		port_link <= 2'b11;
	endtask
	task wrap_up;
		if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_start;
		t_ctrl;
		t_hold;
		t_age;
		wrap_up;
	end
	// about 1000 cycles expected; ample margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		wrap_up;
	end
endmodule // tb
